/* hdl/sub_backlight_and_regulator_regs.v */
// write-only sub-bank current and four regulator control registers
// assumes a decoder delivers one-cycle write strobes with address and data
`timescale 1ns/1ps
`include "sub_regs_defines.vh"
// How it works
// - sub current drives only sub-bank sinks
// - bit five of sub current ignored
// - one common current for sub sinks
// - sink off if disabled or code zero
// - sub code maps to microamp current
// - regulator one off at zero, else on
// - regulator one voltage table decode
// - bits five, four unused on 1/3/4
// - regulator two three-bit code, zero off
// - regulator two 1.8 V down to 1.2 V
// - regulator three off at zero, else on
// - regulator three decodes like regulator one
// - regulator four off at zero, else on
// - regulator four decodes like regulator one
// - registers write-only, nothing read back
// - sinks not in main bank follow sub
module sub_backlight_and_regulator_regs
(
   input  wire        core_clk_i,
   input  wire        rst_n_i,
   input  wire        wr_strobe_i,
   input  wire [5:0]  wr_addr_i,
   input  wire [5:0]  wr_data_i,
   input  wire [5:0]  sink_enable_bits_i,
   input  wire [2:0]  main_bank_select_code_i,
   output reg  [4:0]  sub_current_code_o,
   output reg  [14:0] sub_current_ua_o,
   output reg  [5:0]  sub_sink_on_o,
   output reg  [5:0]  regulator_enable_o,
   output reg  [47:0] regulator_millivolt_o,
   output wire [3:0]  regulator1_voltage_code_o,
   output wire [2:0]  regulator2_voltage_code_o,
   output wire [3:0]  regulator3_voltage_code_o,
   output wire [3:0]  regulator4_voltage_code_o
);
   // ==========================================================
   // registers
   reg  [4:0]  sub_current_code_reg;
   reg  [3:0]  regulator1_voltage_code_reg;
   reg  [2:0]  regulator2_voltage_code_reg;
   reg  [3:0]  regulator3_voltage_code_reg;
   reg  [3:0]  regulator4_voltage_code_reg;
   reg  [14:0] sub_current_ua_next;
   reg  [5:0]  sub_bank_mask;
   wire [15:0] reg_code_bus;
   wire [3:0]  reg_enable;
   wire [47:0] reg_mv;
   wire [3:0]  reg_narrow;
   integer     i;

   // write-only: no read path exists at all
   always @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sub_current_code_reg        <= 5'h00;
         regulator1_voltage_code_reg <= 4'h0;
         regulator2_voltage_code_reg <= 3'h0;
         regulator3_voltage_code_reg <= 4'h0;
         regulator4_voltage_code_reg <= 4'h0;
      end
      else if (wr_strobe_i)
      begin
         case (wr_addr_i)
            `ADDR_SUB_BANK_CURRENT:
               sub_current_code_reg <= wr_data_i[`SUB_CODE_MSB:0];
            `ADDR_REGULATOR1_CONTROL:
               regulator1_voltage_code_reg <= wr_data_i[`REG_WIDE_CODE_MSB:0];
            `ADDR_REGULATOR2_CONTROL:
               regulator2_voltage_code_reg <= wr_data_i[`REG_NARROW_CODE_MSB:0];
            `ADDR_REGULATOR3_CONTROL:
               regulator3_voltage_code_reg <= wr_data_i[`REG_WIDE_CODE_MSB:0];
            `ADDR_REGULATOR4_CONTROL:
               regulator4_voltage_code_reg <= wr_data_i[`REG_WIDE_CODE_MSB:0];
            default:
               sub_current_code_reg <= sub_current_code_reg;
         endcase
      end
   end

   assign regulator1_voltage_code_o = regulator1_voltage_code_reg;
   assign regulator2_voltage_code_o = regulator2_voltage_code_reg;
   assign regulator3_voltage_code_o = regulator3_voltage_code_reg;
   assign regulator4_voltage_code_o = regulator4_voltage_code_reg;

   // ==========================================================
   // sub current decode in microamps
   always @*
   begin
      sub_current_ua_next = 15'h0000;
      if (sub_current_code_reg < `SUB_CODE_FIRST_VALID)
         sub_current_ua_next = 15'h0000;
      else if (sub_current_code_reg <= 5'h0D)
         sub_current_ua_next = {10'h000, sub_current_code_reg - 5'h03} * 15'h01F4;
      else if (sub_current_code_reg <= 5'h1D)
         sub_current_ua_next = {10'h000, sub_current_code_reg - 5'h08} * 15'h03E8;
      else if (sub_current_code_reg == 5'h1E)
         sub_current_ua_next = 15'h59D8;
      else
         sub_current_ua_next = 15'h61A8;
   end

   // ==========================================================
   // sub bank membership from the main bank select code
   always @*
   begin
      sub_bank_mask = 6'h00;
      for (i = 0; i < `SINK_COUNT; i = i + 1)
      begin
         // codes 1..5 hand the top sinks to the sub bank
         if ((main_bank_select_code_i != 3'h0) && (main_bank_select_code_i <= `BANK_SEL_MAX)
             && (i >= `SINK_COUNT - main_bank_select_code_i))
            sub_bank_mask[i] = 1'b1;
      end
   end

   // ==========================================================
   // regulator decoders, one per regulator
   assign reg_code_bus = {regulator4_voltage_code_reg, regulator3_voltage_code_reg,
                          1'b0, regulator2_voltage_code_reg, regulator1_voltage_code_reg};
   assign reg_narrow   = 4'b0010;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : gen_reg
         regulator_decode u_dec
         (
            .code_i      (reg_code_bus[4*g+3:4*g]),
            .narrow_i    (reg_narrow[g]),
            .enable_o    (reg_enable[g]),
            .millivolt_o (reg_mv[12*g+11:12*g])
         );
      end
   endgenerate

   // ==========================================================
   // registered outputs
   always @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sub_current_code_o    <= 5'h00;
         sub_current_ua_o      <= 15'h0000;
         sub_sink_on_o         <= 6'h00;
         regulator_enable_o    <= 6'h00;
         regulator_millivolt_o <= 48'h0;
      end
      else
      begin
         sub_current_code_o    <= sub_current_code_reg;
         sub_current_ua_o      <= sub_current_ua_next;
         // main-bank sinks never see the sub current
         sub_sink_on_o         <= sub_bank_mask & sink_enable_bits_i
                                  & {6{sub_current_ua_next != 15'h0000}};
         regulator_enable_o    <= {2'b00, reg_enable};
         regulator_millivolt_o <= reg_mv;
      end
   end
endmodule

/* hdl/sub_regs_defines.vh */
// sub-bank current and regulator register constants
// assumes inclusion by bare name from design files
`ifndef SUB_REGS_DEFINES_VH
`define SUB_REGS_DEFINES_VH
// register addresses
`define ADDR_SUB_BANK_CURRENT   6'h02
`define ADDR_REGULATOR1_CONTROL 6'h05
`define ADDR_REGULATOR2_CONTROL 6'h06
`define ADDR_REGULATOR3_CONTROL 6'h07
`define ADDR_REGULATOR4_CONTROL 6'h08
// field positions
`define SUB_CODE_MSB            4
`define REG_WIDE_CODE_MSB       3
`define REG_NARROW_CODE_MSB     2
// reset value of every register
`define REG_RESET_VALUE         6'h00
// current codes below this are reserved, zero is off
`define SUB_CODE_FIRST_VALID    5'h04
// sink count and highest main bank select code
`define SINK_COUNT              6
`define BANK_SEL_MAX            3'h5
`endif

/* hdl/regulator_decode.v */
// decodes a regulator code into enable and output millivolts
// assumes the code is already masked to its documented width
`timescale 1ns/1ps
module regulator_decode
(
   input  wire [3:0]  code_i,
   input  wire        narrow_i,
   output reg         enable_o,
   output reg  [11:0] millivolt_o
);
   always @*
   begin
      enable_o    = (code_i != 4'h0);
      millivolt_o = 12'h000;
      if (narrow_i)
      begin
         // 1.8 V at code 1, 0.1 V down per code
         if (code_i[2:0] != 3'h0)
            millivolt_o = 12'h708 - ({9'h000, code_i[2:0]} - 12'h001) * 12'h064;
      end
      else
      begin
         case (code_i)
            4'h0:    millivolt_o = 12'h000;
            4'hB:    millivolt_o = 12'h898;
            4'hC:    millivolt_o = 12'h708;
            4'hD:    millivolt_o = 12'h6A4;
            4'hE:    millivolt_o = 12'h640;
            4'hF:    millivolt_o = 12'h5DC;
            // 3.3 V at code 1 down to 2.4 V at code 10
            default: millivolt_o = 12'hCE4 - ({8'h00, code_i} - 12'h001) * 12'h064;
         endcase
      end
   end
endmodule

/* testbench/sub_regs_asserts.sv */
// checker for the sub current and regulator registers
// assumes binding onto the register bank top with matching port names
`timescale 1ns/1ps
module sub_regs_asserts
(
   input wire        core_clk_i,
   input wire        rst_n_i,
   input wire        wr_strobe_i,
   input wire [5:0]  wr_addr_i,
   input wire [5:0]  wr_data_i,
   input wire [2:0]  main_bank_select_code_i,
   input wire [4:0]  sub_current_code_o,
   input wire [14:0] sub_current_ua_o,
   input wire [5:0]  sub_sink_on_o,
   input wire [5:0]  regulator_enable_o,
   input wire [3:0]  regulator1_voltage_code_o,
   input wire [2:0]  regulator2_voltage_code_o,
   input wire [3:0]  regulator4_voltage_code_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   // stored sub code reaches its output two edges after the strobe
   property p_sub_code;
      wr_strobe_i && wr_addr_i == 6'h02 |-> ##2 sub_current_code_o == ($past(wr_data_i, 2) & 6'h1F);
   endproperty
   a_sub_code: assert property (p_sub_code) else $error("sub code store");
   property p_reg1; wr_strobe_i && wr_addr_i == 6'h05 |=> regulator1_voltage_code_o == ($past(wr_data_i) & 6'h0F); endproperty
   a_reg1: assert property (p_reg1) else $error("reg1 code store");
   property p_reg2; wr_strobe_i && wr_addr_i == 6'h06 |=> regulator2_voltage_code_o == ($past(wr_data_i) & 6'h07); endproperty
   a_reg2: assert property (p_reg2) else $error("reg2 code store");
   property p_reg4; wr_strobe_i && wr_addr_i == 6'h08 |=> regulator4_voltage_code_o == ($past(wr_data_i) & 6'h0F); endproperty
   a_reg4: assert property (p_reg4) else $error("reg4 code store");
   property p_hold; !(wr_strobe_i && wr_addr_i == 6'h02) |-> ##2 $stable(sub_current_code_o); endproperty
   a_hold: assert property (p_hold) else $error("sub code moved");
   property p_en; regulator_enable_o[5:4] == 2'h0 && regulator_enable_o[1] == ($past(regulator2_voltage_code_o) != 3'h0); endproperty
   a_en: assert property (p_en) else $error("reg enable");
   property p_ua_zero; sub_current_code_o < 5'h04 |-> sub_current_ua_o == 15'h0000; endproperty
   a_ua_zero: assert property (p_ua_zero) else $error("sub current not zero");
   property p_ua_top; sub_current_code_o == 5'h1F |-> sub_current_ua_o == 15'h61A8; endproperty
   a_ua_top: assert property (p_ua_top) else $error("top current");
   property p_main; $past(main_bank_select_code_i) == 3'h0 |-> sub_sink_on_o == 6'h00; endproperty
   a_main: assert property (p_main) else $error("main sink in sub");
endmodule
bind sub_backlight_and_regulator_regs sub_regs_asserts u_sub_regs_asserts (.*);

/* testbench/host_writer.sv */
// host model: turns a request into one strobe cycle, scrambles idle bus
`timescale 1ns/1ps
module host_writer
(
   input  wire       clk_i,
   input  wire       go_i,
   input  wire [5:0] addr_i,
   input  wire [5:0] data_i,
   output reg        wr_strobe_o = 1'b0,
   output reg  [5:0] wr_addr_o = 6'h00,
   output reg  [5:0] wr_data_o = 6'h00
);
   always @(posedge clk_i)
   begin
      wr_strobe_o <= go_i;
      wr_addr_o <= go_i ? addr_i : ~wr_addr_o;
      wr_data_o <= go_i ? data_i : ~wr_data_o;
   end
endmodule

/* testbench/sub_backlight_and_regulator_regs_tb_top.sv */
// bench: writes every register code except reserved sub codes 1..3 and checks decoded outputs
`timescale 1ns/1ps
module sub_backlight_and_regulator_regs_tb_top;
   reg clk = 1'b0, rst_n = 1'b0, go = 1'b0;
   reg [5:0] ga = 6'h00, gd = 6'h00, en = 6'h3F;
   reg [2:0] sel = 3'h1;
   wire stb;
   wire [5:0] wa, wd, son, ren;
   wire [4:0] sc;
   wire [14:0] ua;
   wire [47:0] mv;
   wire [3:0] c1, c3, c4;
   wire [2:0] c2;
   wire [15:0] codes = {c4, c3, 1'b0, c2, c1};
   integer err_total = 0, num_checks = 0, cyc = 0, c, r, k;
   always #12.5 clk = ~clk;
   host_writer u_host_writer (.clk_i(clk), .go_i(go), .addr_i(ga), .data_i(gd), .wr_strobe_o(stb),
      .wr_addr_o(wa), .wr_data_o(wd));
   sub_backlight_and_regulator_regs u_sub_backlight_and_regulator_regs (.core_clk_i(clk), .rst_n_i(rst_n),
      .wr_strobe_i(stb), .wr_addr_i(wa), .wr_data_i(wd), .sink_enable_bits_i(en), .main_bank_select_code_i(sel),
      .sub_current_code_o(sc), .sub_current_ua_o(ua), .sub_sink_on_o(son), .regulator_enable_o(ren),
      .regulator_millivolt_o(mv), .regulator1_voltage_code_o(c1), .regulator2_voltage_code_o(c2),
      .regulator3_voltage_code_o(c3), .regulator4_voltage_code_o(c4));
   task chk(input [79:0] name, input [47:0] seen, input [47:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp)
         begin
            err_total = err_total + 1;
            $display("BAD %0s exp %0h seen %0h", name, exp, seen);
         end
      end
   endtask
   task wr(input [5:0] a, input [5:0] d);
      begin
         @(posedge clk) go <= 1'b1; ga <= a; gd <= d;
         @(posedge clk) go <= 1'b0;
         repeat (3) @(posedge clk);
         #1;
      end
   endtask
   task close_out;
      begin
         $display("checks %0d errors %0d", num_checks, err_total);
         if (err_total == 0 && num_checks > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 5000)
      begin
         err_total = err_total + 1;
         close_out;
      end
   end
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("reset", {sc, ua, son, ren, mv[9:0]}, 48'h0);
      for (c = 0; c < 32; c = c + 1)
         if (c == 0 || c > 3)
         begin
            wr(6'h02, 6'h20 | c);
            k = c < 4 ? 0 : c < 14 ? c * 500 - 1500 : c < 30 ? (c - 8) * 1000 : c == 30 ? 23000 : 25000;
            chk("sub", {sc, ua, son}, {c[4:0], k[14:0], k ? 6'h20 : 6'h00});
         end
      wr(6'h03, 6'h01);
      chk("unmapped", sc, 5'h1F);
      en <= 6'h2D;
      for (r = 0; r < 8; r = r + 1)
      begin
         sel <= r;
         repeat (3) @(posedge clk);
         #1;
         chk("bank", son, (r > 0 && r < 6) ? ((6'h3F << (6 - r)) & 6'h2D) : 6'h00);
      end
      for (r = 1; r < 5; r = r + 1)
         for (c = 0; c < (r == 2 ? 8 : 16); c = c + 1)
         begin
            wr(4 + r, c[5:0]);
            k = c == 0 ? 0 : r == 2 ? 1900 - 100 * c : c < 11 ? 3400 - 100 * c : c == 11 ? 2200 : 3000 - 100 * c;
            chk("regulator", {codes[(r - 1) * 4 +: 4], ren[r - 1], mv[(r - 1) * 12 +: 12]},
               {c[3:0], c != 0, k[11:0]});
         end
      close_out;
   end
endmodule
